// ===== dv/drive_map_status_monitor.sv
// port checker for the drive map and status block
`timescale 1ns/10ps
module drive_map_status_monitor (
   input wire       sys_clk_i,
   input wire       sys_rst_i,
   input wire [2:0] host_addr_i,
   input wire       host_rd_n_i,
   input wire       host_wr_n_i,
   input wire [7:0] host_data_i,
   input wire [7:0] host_data_o,
   input wire [7:0] host_data_oe_o,
   input wire       rate_wr_o,
   input wire [7:0] rate_data_o,
   input wire       soft_rst_i,
   input wire       enhanced_register_enable_i,
   input wire       four_drive_config_i,
   input wire       select_i,
   input wire       motor_0_i,
   input wire       motor_1_i,
   input wire       polled_mode_i,
   input wire       drive_select_line_0_n_o,
   input wire       drive_select_line_1_n_o,
   input wire       motor_line_0_n_o,
   input wire       motor_line_1_n_o,
   input wire       tape_precomp_o,
   input wire       boot_swap_o
);
reg  [8:0] up_cnt_r;
reg  [2:0] rd_gap_r;
reg  [7:0] wr_byte_r;
wire       st_rd = host_data_oe_o != 8'h00 && host_addr_i == 3'h4;
default clocking mon_cb @(posedge sys_clk_i); endclocking
default disable iff (sys_rst_i);
////////////////////////////////////////////////////////////
// age since reset, gap since read strobe, last byte written
always @(posedge sys_clk_i) begin
   if (sys_rst_i || soft_rst_i)
      up_cnt_r <= 9'h000;
   else if (up_cnt_r != 9'h1FF)
      up_cnt_r <= up_cnt_r + 9'h001;
   if (sys_rst_i || !host_rd_n_i)
      rd_gap_r <= 3'h0;
   else if (rd_gap_r != 3'h7)
      rd_gap_r <= rd_gap_r + 3'h1;
   if (!host_wr_n_i)
      wr_byte_r <= host_data_i;
end
////////////////////////////////////////////////////////////
// select and motor pin checks skip the edge after reset, whose past is reset
select_swap_a: assert property (
   !$past(sys_rst_i) |-> drive_select_line_0_n_o == $past(select_i ^ boot_swap_o)
   && drive_select_line_1_n_o == !drive_select_line_0_n_o) else $error("select pins");
motor_swap_a: assert property (
   !$past(sys_rst_i) |-> motor_line_0_n_o == !$past(boot_swap_o ? motor_1_i : motor_0_i)
   && motor_line_1_n_o == !$past(boot_swap_o ? motor_0_i : motor_1_i)) else $error("motor pins");
rate_pulse_a: assert property (
   rate_wr_o |-> rate_data_o == wr_byte_r ##1 !rate_wr_o) else $error("rate write");
map_upper_zero_a: assert property (
   host_data_oe_o != 8'h00 && host_addr_i == 3'h3 |-> host_data_o[7:3] == 5'h00)
   else $error("map upper bits");
map_float_a: assert property (
   host_data_oe_o != 8'h00 |-> host_data_oe_o ==
   ((host_addr_i == 3'h3 && !enhanced_register_enable_i) ? 8'h03 : 8'hFF)) else $error("oe");
read_only_oe_a: assert property (
   host_data_oe_o != 8'h00 |-> rd_gap_r < 3'h6 && host_wr_n_i) else $error("oe outside read");
status_init_a: assert property (
   st_rd && up_cnt_r < 9'h0F0 |-> host_data_o == 8'h00) else $error("status before ready");
dir_needs_req_a: assert property (
   st_rd && host_data_o[6] |-> host_data_o[7]) else $error("direction without request");
polled_bit_a: assert property (
   st_rd && host_data_o[5] |-> polled_mode_i) else $error("polled bit");
two_drive_mask_a: assert property (
   st_rd && !four_drive_config_i |-> host_data_o[3:2] == 2'h0) else $error("status 3:2");
tape_drive1_a: assert property (
   tape_precomp_o |-> $past(select_i)) else $error("tape on drive 0");
endmodule
bind drive_map_status drive_map_status_monitor drive_map_status_monitor_i (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .host_addr_i(host_addr_i),
   .host_rd_n_i(host_rd_n_i), .host_wr_n_i(host_wr_n_i), .host_data_i(host_data_i),
   .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o), .rate_wr_o(rate_wr_o),
   .rate_data_o(rate_data_o), .soft_rst_i(soft_rst_i), .select_i(select_i),
   .enhanced_register_enable_i(enhanced_register_enable_i), .motor_0_i(motor_0_i),
   .four_drive_config_i(four_drive_config_i), .motor_1_i(motor_1_i),
   .polled_mode_i(polled_mode_i), .drive_select_line_0_n_o(drive_select_line_0_n_o),
   .drive_select_line_1_n_o(drive_select_line_1_n_o), .motor_line_0_n_o(motor_line_0_n_o),
   .motor_line_1_n_o(motor_line_1_n_o), .tape_precomp_o(tape_precomp_o),
   .boot_swap_o(boot_swap_o)
);

// ===== dv/drive_map_status_tb_top.sv
// self-checking bench for the drive map and status block
`timescale 1ns/10ps
module drive_map_status_tb_top;
reg         sys_clk = 1'b0;
reg         sys_rst = 1'b1;
reg         soft_rst, pdown, ena, four, sel, m0, m1, polled, exec_ph, irq, f_rdy;
reg         f_hrd, f_xfer, c_first, c_last, c_res, r_last, s_iss, n_rd;
reg  [1:0]  s_drv;
reg  [31:0] lfsr;
reg  [7:0]  d;
wire        cs_n, rd_n, wr_n, rd_valid, rate_wr, tape_pc, swap, l0_n, l1_n, m0_n, m1_n;
wire [2:0]  addr;
wire [7:0]  wdata, rdata, oe, rate_d;
wire [15:0] rd_word;
reg  [15:0] exp_q[$];
integer     err_count = 0, total_checks = 0, k, j, rate_n = 0;
drive_map_status drive_map_status_i (
   .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .host_cs_n_i(cs_n), .host_addr_i(addr),
   .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_data_i(wdata), .host_data_o(rdata),
   .host_data_oe_o(oe), .rate_wr_o(rate_wr), .rate_data_o(rate_d), .soft_rst_i(soft_rst),
   .powerdown_i(pdown), .enhanced_register_enable_i(ena), .four_drive_config_i(four),
   .select_i(sel), .motor_0_i(m0), .motor_1_i(m1), .polled_mode_i(polled),
   .exec_phase_i(exec_ph), .floppy_interrupt_line_i(irq), .fifo_ready_i(f_rdy),
   .fifo_host_read_i(f_hrd), .fifo_xfer_i(f_xfer), .cmd_first_byte_i(c_first),
   .cmd_last_byte_i(c_last), .cmd_has_result_i(c_res), .result_last_read_i(r_last),
   .seek_issue_i(s_iss), .seek_drive_i(s_drv), .sense_read_i(n_rd), .sense_drive_i(s_drv),
   .drive_select_line_0_n_o(l0_n), .drive_select_line_1_n_o(l1_n), .motor_line_0_n_o(m0_n),
   .motor_line_1_n_o(m1_n), .tape_precomp_o(tape_pc), .boot_swap_o(swap)
);
isa_host_model isa_host_model_i (
   .sys_clk_i(sys_clk), .data_i(rdata), .oe_i(oe), .cs_n_o(cs_n), .addr_o(addr),
   .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(wdata), .rd_valid_o(rd_valid), .rd_word_o(rd_word)
);
////////////////////////////////////////////////////////////
// free-running 100 MHz clock
always #5 sys_clk = ~sys_clk;
function [31:0] lfsr_next(input [31:0] s);
   lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task tick;
   begin
      @(posedge sys_clk);
      #1;
   end
endtask
task compare(input string name, input [15:0] exp, input [15:0] got);
   begin
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
   end
endtask
task rd_chk(input [2:0] a, input [15:0] exp);
   begin
      exp_q.push_back(exp);
      isa_host_model_i.io_cycle(1'b0, a, 8'h00);
   end
endtask
task complete_run;
   begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
endtask
// read results arrive in request order and meet the oldest note
always @(posedge sys_clk)
   if (rd_valid)
      compare("host read", exp_q.pop_front(), rd_word);
// data-rate strobes seen; writes at the mapping offset must never add one
always @(posedge sys_clk)
   if (rate_wr)
      rate_n++;
// a hung run still reaches the verdict
initial begin
   repeat (100000) @(posedge sys_clk);
   err_count++;
   complete_run;
end
////////////////////////////////////////////////////////////
// main sequence: reset, mapping, pins, status handshake, seek flags
initial begin
   {soft_rst, pdown, ena, four, sel, m0, m1, polled, exec_ph, irq} = 10'h000;
   {f_hrd, f_xfer, c_first, c_last, c_res, r_last, s_iss, n_rd, s_drv} = 10'h000;
   f_rdy = 1'b1;
   lfsr = 32'h3F6036C7;
   repeat (12) @(posedge sys_clk);
   #1;
   sys_rst = 1'b0;
   rd_chk(3'h3, 16'h0300);
   rd_chk(3'h4, 16'hFF00);
   // next read strobe falls 250 cycles after reset release
   repeat (221) tick;
   rd_chk(3'h4, 16'hFF80);
   ena = 1'b1;
   for (k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      d = lfsr[7:0] & 8'hFD;
      isa_host_model_i.io_cycle(1'b1, 3'h3, d);
      rd_chk(3'h3, {8'hFF, 5'h00, d[2:0]});
   end
   isa_host_model_i.io_cycle(1'b1, 3'h4, lfsr[15:8]);
   compare("rate byte", {8'h00, rate_d}, {8'h00, lfsr[15:8]});
   rd_chk(3'h4, 16'hFF80);
   // every select and swap mix with exactly one motor on, drive 1 marked as tape
   for (k = 0; k < 8; k++) begin
      isa_host_model_i.io_cycle(1'b1, 3'h3, {5'h00, k[2], 2'h1});
      {sel, m0, m1, four} = {k[0], k[1], ~k[1], k[1]};
      tick;
      tick;
      compare("drive pins", {10'h000, l0_n, l1_n, m0_n, m1_n, tape_pc, swap},
         {10'h000, k[0] ^ k[2], ~(k[0] ^ k[2]), ~(k[1] ^ k[2]), k[1] ^ k[2], k[0], k[2]});
   end
   four = 1'b0;
   tick;
   soft_rst = 1'b1;
   tick;
   soft_rst = 1'b0;
   rd_chk(3'h4, 16'hFF00);
   rd_chk(3'h3, 16'hFF05);
   // next read strobe falls 250 cycles after the soft reset edge
   repeat (221) tick;
   rd_chk(3'h4, 16'hFF80);
   c_first = 1'b1;
   tick;
   c_first = 1'b0;
   rd_chk(3'h4, 16'hFF90);
   f_hrd = 1'b1;
   rd_chk(3'h4, 16'hFFD0);
   f_hrd = 1'b0;
   c_last = 1'b1;
   tick;
   c_last = 1'b0;
   rd_chk(3'h4, 16'hFF80);
   f_xfer = 1'b1;
   tick;
   f_xfer = 1'b0;
   rd_chk(3'h4, 16'hFF00);
   f_rdy = 1'b0;
   tick;
   tick;
   f_rdy = 1'b1;
   rd_chk(3'h4, 16'hFF80);
   {polled, exec_ph} = 2'h3;
   for (k = 0; k < 2; k++) begin
      irq = k[0];
      rd_chk(3'h4, {8'hFF, k[0], 7'h20});
   end
   {polled, exec_ph, irq} = 3'h0;
   // seek flags per drive, bits 3:2 hidden in two-drive mode
   for (j = 0; j < 2; j++)
      for (k = 0; k < 4; k++) begin
         {four, s_drv, s_iss} = {j[0], k[1:0], 1'b1};
         tick;
         s_iss = 1'b0;
         rd_chk(3'h4, 16'hFF80 | ((j == 1 || k < 2) ? 16'h0001 << k : 16'h0000));
         n_rd = 1'b1;
         tick;
         n_rd = 1'b0;
         rd_chk(3'h4, 16'hFF80);
      end
   // powerdown exit reopens the initialisation window
   pdown = 1'b1;
   tick;
   pdown = 1'b0;
   rd_chk(3'h4, 16'hFF00);
   repeat (250) tick;
   rd_chk(3'h4, 16'hFF80);
   for (k = 0; k < 20 && exp_q.size() != 0; k++)
      tick;
   if (exp_q.size() != 0)
      err_count++;
   compare("rate pulses", rate_n[15:0], 16'h0001);
   complete_run;
end
endmodule

// ===== dv/isa_host_model.sv
// behavioural host driving the 8-bit controller I/O pins
`timescale 1ns/10ps
module isa_host_model (
   input  wire        sys_clk_i,
   input  wire [7:0]  data_i,
   input  wire [7:0]  oe_i,
   output reg         cs_n_o = 1'b1,
   output reg  [2:0]  addr_o = 3'h0,
   output reg         rd_n_o = 1'b1,
   output reg         wr_n_o = 1'b1,
   output reg  [7:0]  data_o = 8'hA5,
   output reg         rd_valid_o = 1'b0,
   output reg  [15:0] rd_word_o = 16'h0000
);
////////////////////////////////////////////////////////////
// released data pins wander so a stale byte never looks valid
always @(posedge sys_clk_i)
   if (cs_n_o)
      data_o <= ~data_o;
// strobes and qualifiers held well past the pin synchronisers
task io_cycle(input wr, input [2:0] a, input [7:0] d);
   begin
      @(posedge sys_clk_i);
      #1;
      cs_n_o = 1'b0;
      addr_o = a;
      data_o = d;
      wr_n_o = !wr;
      rd_n_o = wr;
      repeat (5) @(posedge sys_clk_i);
      rd_word_o = {oe_i, data_i & oe_i};
      #1;
      rd_valid_o = !wr;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      rd_valid_o = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1;
      cs_n_o = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
   end
endtask
endmodule

// ===== shared/fdc_map_defs.vh
// register offsets, field positions, reset values and timing for the drive map and status block
// Behaviour
// - hardware reset clears the whole drive-mapping register to zero.
// - output-control software reset leaves the drive-mapping register untouched.
// - mapping bits 7:2 drive the bus only while enhanced registers are enabled.
// - boot swap 0 keeps select/motor pairs straight; 1 crosses them over.
// - same swap in four-drive configuration; only drive 0 or 1 boots.
// - tape bit is read/write; it only steers precompensation for drive 1.
// - drive 0 is never treated as a tape drive.
// - status reads zero after any reset or powerdown until initialisation ends.
// - status reaches ready-for-command within 2.5 us of hard or soft reset.
// - DMA mode shows 90h while busy, D0h while results await the host.
// - transfer request drops after each byte, rises when next byte is ready.
// - in non-DMA execution the transfer request mirrors the interrupt line.
// - direction bit: 1 host reads the FIFO, 0 host writes it.
// - polled-execution bit is set during execution when non-DMA mode selected.
// - command busy sets on first command byte, clears at command end.
// - per-drive seek flag sets after seek command, clears on sense read.
// - status bits 3:2 read zero in two-drive configuration.
// - writes at the status offset go to the data-rate register instead.
// - output-control select bit picks select line 0 or 1, after the swap.
`ifndef FDC_MAP_DEFS_VH
`define FDC_MAP_DEFS_VH

// host offsets from the controller base
`define OFS_DRIVE_MAPPING    3'h3
`define OFS_MAIN_STATUS      3'h4

// drive-mapping register fields
`define MAP_RESET            8'h00
`define MAP_TAPE_BIT         0
`define MAP_FOUR_BIT         1
`define MAP_SWAP_BIT         2
`define MAP_ENH_LSB          2
`define MAP_WR_MASK          8'h07

// status register fields
`define ST_REQUEST_BIT       7
`define ST_DIR_BIT           6
`define ST_POLLED_BIT        5
`define ST_BUSY_BIT          4
`define ST_RESET             8'h00
`define ST_TWO_DRIVE_MASK    8'hF3

// timing: longest time to ready, rounded down to cycles
`define CLK_PERIOD_NS        10
`define READY_TIME_NS        2500
`define READY_CYCLES         (`READY_TIME_NS / `CLK_PERIOD_NS)
`define READY_CNT_W          9
// last count of the window, already at the counter's own width
`define READY_LAST           9'h0F9

`endif

// ===== src/drive_map_status.v
// drive-mapping register and main handshake status register of the floppy controller
`timescale 1ns/10ps
`include "fdc_map_defs.vh"
module drive_map_status (
   input  wire       sys_clk_i,
   input  wire       sys_rst_i,
   // 8-bit host I/O cycle pins
   input  wire       host_cs_n_i,
   input  wire [2:0] host_addr_i,
   input  wire       host_rd_n_i,
   input  wire       host_wr_n_i,
   input  wire [7:0] host_data_i,
   output wire [7:0] host_data_o,
   output wire [7:0] host_data_oe_o,
   // data-rate register write path
   output wire       rate_wr_o,
   output wire [7:0] rate_data_o,
   // controller state, same clock
   input  wire       soft_rst_i,
   input  wire       powerdown_i,
   input  wire       enhanced_register_enable_i,
   input  wire       four_drive_config_i,
   input  wire       select_i,
   input  wire       motor_0_i,
   input  wire       motor_1_i,
   input  wire       polled_mode_i,
   input  wire       exec_phase_i,
   input  wire       floppy_interrupt_line_i,
   input  wire       fifo_ready_i,
   input  wire       fifo_host_read_i,
   input  wire       fifo_xfer_i,
   input  wire       cmd_first_byte_i,
   input  wire       cmd_last_byte_i,
   input  wire       cmd_has_result_i,
   input  wire       result_last_read_i,
   input  wire       seek_issue_i,
   input  wire [1:0] seek_drive_i,
   input  wire       sense_read_i,
   input  wire [1:0] sense_drive_i,
   // drive pins and precompensation steering
   output wire       drive_select_line_0_n_o,
   output wire       drive_select_line_1_n_o,
   output wire       motor_line_0_n_o,
   output wire       motor_line_1_n_o,
   output wire       tape_precomp_o,
   output wire       boot_swap_o
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: strobes, address, chip select and data all come from
   // the host bus, outside this clock, so every one passes two flops

   reg  [13:0] pin_s1_r;
   reg  [13:0] pin_s2_r;
   wire [13:0] pin_raw;

   assign pin_raw = {host_cs_n_i, host_addr_i, host_rd_n_i, host_wr_n_i, host_data_i};

   // idle bus levels on reset keep a false strobe edge from firing
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pin_s1_r <= 14'h3FFF;
         pin_s2_r <= 14'h3FFF;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end

   wire       cs_n_s;
   wire [2:0] addr_s;
   wire       rd_n_s;
   wire       wr_n_s;
   wire [7:0] wdata_s;

   assign cs_n_s  = pin_s2_r[13];
   assign addr_s  = pin_s2_r[12:10];
   assign rd_n_s  = pin_s2_r[9];
   assign wr_n_s  = pin_s2_r[8];
   assign wdata_s = pin_s2_r[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // strobe edge detection on the synchronised copies only

   reg rd_n_d_r;
   reg wr_n_d_r;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rd_n_d_r <= 1'b1;
         wr_n_d_r <= 1'b1;
      end else begin
         rd_n_d_r <= rd_n_s;
         wr_n_d_r <= wr_n_s;
      end
   end

   wire sel_map;
   wire sel_status;
   wire wr_edge;
   wire rd_edge;

   // offset decode; base decode happens upstream in host_cs_n_i
   assign sel_map    = !cs_n_s && (addr_s == `OFS_DRIVE_MAPPING);
   assign sel_status = !cs_n_s && (addr_s == `OFS_MAIN_STATUS);
   // write data is taken at the trailing edge of the write strobe, when stable
   assign wr_edge    = wr_n_s && !wr_n_d_r;
   assign rd_edge    = !rd_n_s && rd_n_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // drive-mapping register

   reg [7:0] map_r;

   // bit 1 is kept as written; two-drive software must write it as 0, and
   // nothing here reads it, so a stray 1 only shows up on a read back
   // only the hard reset touches it, soft resets are not wired in
   always @(posedge sys_clk_i) begin
      if (sys_rst_i)
         map_r <= `MAP_RESET;
      else if (wr_edge && sel_map)
         map_r <= wdata_s & `MAP_WR_MASK;
   end

   wire boot_swap;
   wire tape_assign;

   assign boot_swap   = map_r[`MAP_SWAP_BIT];
   assign tape_assign = map_r[`MAP_TAPE_BIT];
   assign boot_swap_o = boot_swap;

   ////////////////////////////////////////////////////////////////////////////
   // data-rate register shares the status offset; writes are handed on

   reg       rate_wr_r;
   reg [7:0] rate_data_r;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rate_wr_r   <= 1'b0;
         rate_data_r <= 8'h00;
      end else begin
         rate_wr_r <= wr_edge && sel_status;
         if (wr_edge && sel_status)
            rate_data_r <= wdata_s;
      end
   end

   assign rate_wr_o   = rate_wr_r;
   assign rate_data_o = rate_data_r;

   ////////////////////////////////////////////////////////////////////////////
   // drive select and motor remapping onto the active-low pins

   reg sel0_n_r;
   reg sel1_n_r;
   reg mot0_n_r;
   reg mot1_n_r;

   // logical drive 0/1 lands on line 0/1, crossed when boot swap is set;
   // four-drive mode uses the same crossing; select_i names drive 0 or 1
   // only, so drives 2 and 3 must be decoded outside this block, and only
   // drive 0 or 1 can ever be the boot drive
   wire log_sel1;
   wire phys_sel1;

   assign log_sel1  = select_i;
   assign phys_sel1 = log_sel1 ^ boot_swap;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sel0_n_r <= 1'b1;
         sel1_n_r <= 1'b1;
         mot0_n_r <= 1'b1;
         mot1_n_r <= 1'b1;
      end else begin
         sel0_n_r <= phys_sel1;
         sel1_n_r <= !phys_sel1;
         mot0_n_r <= !(boot_swap ? motor_1_i : motor_0_i);
         mot1_n_r <= !(boot_swap ? motor_0_i : motor_1_i);
      end
   end

   assign drive_select_line_0_n_o = sel0_n_r;
   assign drive_select_line_1_n_o = sel1_n_r;
   assign motor_line_0_n_o        = mot0_n_r;
   assign motor_line_1_n_o        = mot1_n_r;

   // tape precompensation only for logical drive 1, never drive 0
   reg tape_pc_r;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i)
         tape_pc_r <= 1'b0;
      else
         tape_pc_r <= tape_assign && log_sel1;
   end

   assign tape_precomp_o = tape_pc_r;

   ////////////////////////////////////////////////////////////////////////////
   // initialisation window after hard reset, soft reset or powerdown exit

   reg  pd_d_r;
   wire init_restart;
   wire init_ready;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i)
         pd_d_r <= 1'b0;
      else
         pd_d_r <= powerdown_i;
   end

   // oscillator settling is not modelled: the window is a fixed count
   // held soft reset or powerdown keeps the window open
   assign init_restart = soft_rst_i || powerdown_i || pd_d_r;

   init_ready_timer u_init (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .restart_i (init_restart),
      .ready_o   (init_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command busy flag; set wins over a clear in the same cycle

   reg busy_r;
   reg busy_nxt;

   always @* begin
      busy_nxt = busy_r;
      if (result_last_read_i || (cmd_last_byte_i && !cmd_has_result_i))
         busy_nxt = 1'b0;
      if (cmd_first_byte_i)
         busy_nxt = 1'b1;
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i || soft_rst_i)
         busy_r <= 1'b0;
      else
         busy_r <= busy_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer request hold-off: dropped after each host byte until the fifo
   // side withdraws its ready, so a stale ready never re-arms the request

   reg xfer_hold_r;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i || soft_rst_i)
         xfer_hold_r <= 1'b0;
      else if (fifo_xfer_i)
         xfer_hold_r <= 1'b1;
      else if (!fifo_ready_i)
         xfer_hold_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-drive seek flags; 2 and 3 are kept in both configurations, shown only in four-drive

   wire [3:0] seek_busy;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_seek
         seek_busy_flag #(.DRIVE(gi[1:0])) u_flag (
            .sys_clk_i     (sys_clk_i),
            .sys_rst_i     (sys_rst_i),
            .soft_rst_i    (soft_rst_i),
            .seek_issue_i  (seek_issue_i),
            .seek_drive_i  (seek_drive_i),
            .sense_read_i  (sense_read_i),
            .sense_drive_i (sense_drive_i),
            .busy_o        (seek_busy[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // status assembly: 80h idle, 90h busy, D0h awaiting a result read in DMA

   // whole byte reads zero until the window closes, so a polling host
   // never acts on a request raised by half-initialised state
   reg  [7:0] status_now;
   wire       polled_exec;
   wire       request;

   assign polled_exec = polled_mode_i && exec_phase_i;
   // non-DMA execution hands the request over to the interrupt line
   assign request = polled_exec ? floppy_interrupt_line_i
                               : (fifo_ready_i && !xfer_hold_r);

   always @* begin
      status_now = `ST_RESET;
      if (init_ready) begin
         status_now[`ST_REQUEST_BIT] = request;
         status_now[`ST_DIR_BIT]     = request && fifo_host_read_i;
         status_now[`ST_POLLED_BIT]  = polled_exec;
         status_now[`ST_BUSY_BIT]    = busy_r;
         status_now[3:0]             = seek_busy;
         if (!four_drive_config_i)
            status_now = status_now & `ST_TWO_DRIVE_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: value latched at the start of the read strobe and held
   // for the whole cycle, so the host never sees it change mid-read;
   // other offsets belong to neighbouring registers and never drive here

   reg [7:0] rdata_r;
   reg       rd_map_r;
   reg       rd_act_r;

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_r  <= 8'h00;
         rd_map_r <= 1'b0;
         rd_act_r <= 1'b0;
      end else if (rd_edge && (sel_map || sel_status)) begin
         rdata_r  <= sel_map ? map_r : status_now;
         rd_map_r <= sel_map;
         rd_act_r <= 1'b1;
      end else if (rd_n_s) begin
         rd_act_r <= 1'b0;
      end
   end

   // upper mapping bits float unless enhanced registers are enabled
   wire [7:0] oe_mask;

   assign oe_mask = (rd_map_r && !enhanced_register_enable_i) ?
                    ~(8'hFF << `MAP_ENH_LSB) : 8'hFF;
   assign host_data_o    = rdata_r;
   assign host_data_oe_o = rd_act_r ? oe_mask : 8'h00;

endmodule

// ===== src/init_ready_timer.v
// counts the initialisation window after a reset or powerdown recovery
`timescale 1ns/10ps
`include "fdc_map_defs.vh"
module init_ready_timer (
   input  wire sys_clk_i,
   input  wire sys_rst_i,
   input  wire restart_i,
   output wire ready_o
);
   reg [`READY_CNT_W-1:0] cnt_r;
   reg                    ready_r;

   // ready exactly READY_CYCLES edges after the last restart
   always @(posedge sys_clk_i) begin
      if (sys_rst_i || restart_i) begin
         cnt_r   <= {`READY_CNT_W{1'b0}};
         ready_r <= 1'b0;
      end else if (!ready_r) begin
         if (cnt_r == `READY_LAST)
            ready_r <= 1'b1;
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign ready_o = ready_r;
endmodule

// ===== src/seek_busy_flag.v
// one per-drive seek-busy flag, set by a seek issue and cleared by a sense read
`timescale 1ns/10ps
module seek_busy_flag #(
   parameter [1:0] DRIVE = 2'h0
) (
   input  wire       sys_clk_i,
   input  wire       sys_rst_i,
   input  wire       soft_rst_i,
   input  wire       seek_issue_i,
   input  wire [1:0] seek_drive_i,
   input  wire       sense_read_i,
   input  wire [1:0] sense_drive_i,
   output wire       busy_o
);
   reg busy_r;
   reg busy_nxt;

   // set wins over clear so a seek issued while its sense is read is kept
   always @* begin
      busy_nxt = busy_r;
      if (sense_read_i && (sense_drive_i == DRIVE))
         busy_nxt = 1'b0;
      if (seek_issue_i && (seek_drive_i == DRIVE))
         busy_nxt = 1'b1;
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i || soft_rst_i)
         busy_r <= 1'b0;
      else
         busy_r <= busy_nxt;
   end

   assign busy_o = busy_r;
endmodule
